// ### logic/epsc_port.sv
// Functional notes
// R1 - eight-bit data latch in low byte
// R2 - direction bit 0 input, 1 output
// R3 - upper lines: drain bit picks open-drain
// R4 - only drain bits four to seven exist
// R5 - lines zero-three connected while enable bit zero
// R6 - segment lines switch automatically from reset
// R7 - code latched at reset, readable read-only
// R8 - codes 01, 11, 00 select lines
// R9 - code 10: eight lines, CAN masked
// R10 - fixed CAN pin map outside code 10
// R11 - parallel mode: second receive from pin five
// R12 - parallel mode: second transmit on pin six
// R13 - address lines force driver; others plain GPIO
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "epsc_consts.svh"

module epsc_port
    import epsc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // avalon-mm slave
    input  wire logic [17:0] avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // external bus controller
    input  wire logic [7:0]  seg_addr_in,
    input  wire logic [1:0]  bus_port_zero_code_in,
    // can modules
    input  wire logic        first_can_enable_in,
    input  wire logic        second_can_enable_in,
    input  wire logic        can_parallel_in,
    input  wire logic        first_controller_transmit_in,
    input  wire logic        second_controller_transmit_in,
    output logic             first_controller_receive_out,
    output logic             second_controller_receive_out,
    // port lines
    input  wire logic [7:0]  line_pin_in,
    output logic      [7:0]  line_pin_out,
    output logic      [7:0]  line_pin_oe_n_out
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]         port_four_data_latch;    // line_latch_bit per line
    logic [7:0]         port_four_direction;     // line_direction_bit per line
    logic [7:0]         port_four_drain_control; // line_drain_select_bit, 7:4
    logic               shared_pin_enable;       // misc_config_register bit
    epsc_seg_code_type  segment_line_count_code; // caught during reset
    logic [1:0]         code_filt;               // filtered port zero code
    logic [7:0]         pin_filt;                // filtered line levels
    epsc_bus_state_type bus_state;               // bus phase
    epsc_bus_state_type next_bus_state;          // next bus phase
    logic [31:0]        next_readdata;           // read mux result

    logic        bus_req;      // read or write pending
    logic        wr_go;        // write takes effect this edge
    logic        rd_go;        // read data captured this edge
    logic        hit_latch;    // address decodes
    logic        hit_dir;
    logic        hit_drain;
    logic        hit_misc;
    logic        hit_rstcfg;
    logic        hit_pins;
    logic        be_low;       // low byte lane enabled
    logic [7:0]  wr_byte;      // low byte of write data
    logic [7:0]  seg_mask;     // lines carrying segment address
    logic        can_ok;       // CAN allowed on upper lines
    logic        par_active;   // parallel remap in force
    logic        tx6_drive;    // CAN drives line six
    logic        tx7_drive;    // CAN drives line seven
    logic        tx6_level;    // level on line six
    logic [7:0]  alt_drive;    // alternate function owns line
    logic [7:0]  alt_val;      // alternate output level
    logic [7:0]  alt_od;       // alternate open-drain choice
    logic [7:0]  connect;      // line reaches its pin
    logic        next_rx_first;
    logic        next_rx_second;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers

    // selection code pins from port zero
    epsc_sync #(.WIDTH(2)) u_code_sync (
        .clk_in   (clk_in),
        .async_in (bus_port_zero_code_in),
        .filt_out (code_filt)
    );

    // port line levels
    epsc_sync #(.WIDTH(8)) u_pin_sync (
        .clk_in   (clk_in),
        .async_in (line_pin_in),
        .filt_out (pin_filt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reset configuration

    // code follows the pins while reset is held, frozen at release
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            segment_line_count_code <= epsc_seg_code_type'(code_filt); // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus decode

    // one wait state: requests are answered in the second cycle
    assign bus_req    = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & (bus_state == BUS_IDLE);
    assign wr_go      = avs_write_in & (bus_state == BUS_ANSWER);
    // read data is taken in the waiting cycle, so it stands when the wait drops
    assign rd_go      = avs_read_in & (bus_state == BUS_IDLE);
    assign hit_latch  = avs_address_in == {`EPSC_IDX_LATCH, 2'b00};
    assign hit_dir    = avs_address_in == {`EPSC_IDX_DIR, 2'b00};
    assign hit_drain  = avs_address_in == {`EPSC_IDX_DRAIN, 2'b00};
    assign hit_misc   = avs_address_in == {`EPSC_IDX_MISC, 2'b00};
    assign hit_rstcfg = avs_address_in == {`EPSC_IDX_RSTCFG, 2'b00};
    assign hit_pins   = avs_address_in == {`EPSC_IDX_PINS, 2'b00};
    assign be_low     = avs_byteenable_in[0];
    assign wr_byte    = avs_writedata_in[7:0];
    assign next_bus_state = (bus_state == BUS_IDLE && bus_req) ? BUS_ANSWER : BUS_IDLE;

    // read mux; unmapped addresses and unused bits read zero
    assign next_readdata =
        hit_latch  ? {24'h000000, port_four_data_latch} :            // [R1]
        hit_dir    ? {24'h000000, port_four_direction} :
        hit_drain  ? {24'h000000, port_four_drain_control} :          // [R4]
        hit_misc   ? {31'h00000000, shared_pin_enable} :
        hit_rstcfg ? {30'h00000000, segment_line_count_code} :        // [R7]
        hit_pins   ? {24'h000000, pin_filt} :
                     32'h00000000;

    // bus phase and read data
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus_state        <= BUS_IDLE;
            avs_readdata_out <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            if (rd_go) begin
                avs_readdata_out <= next_readdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers

    // writes land at the edge where waitrequest is low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            port_four_data_latch    <= `EPSC_RST_LATCH;
            port_four_direction     <= `EPSC_RST_DIR;
            port_four_drain_control <= `EPSC_RST_DRAIN;
            shared_pin_enable       <= `EPSC_RST_SPE;                 // [R5]
        end else if (wr_go && be_low) begin
            if (hit_latch) begin
                port_four_data_latch <= wr_byte;                      // [R1]
            end
            if (hit_dir) begin
                port_four_direction <= wr_byte;                       // [R2]
            end
            if (hit_drain) begin
                port_four_drain_control <= wr_byte & `EPSC_DRAIN_MASK; // [R4]
            end
            if (hit_misc) begin
                shared_pin_enable <= wr_byte[`EPSC_MISC_SPE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alternate function selection

    // segment lines come straight from the latched code, no software step
    assign seg_mask =
        (segment_line_count_code == SEG_TWO)   ? `EPSC_SEGMASK_TWO :   // [R8]
        (segment_line_count_code == SEG_FOUR)  ? `EPSC_SEGMASK_FOUR :  // [R8]
        (segment_line_count_code == SEG_EIGHT) ? `EPSC_SEGMASK_EIGHT : // [R9]
                                                 `EPSC_SEGMASK_NONE;   // [R6]

    // external memory beats both CAN modules on the upper lines
    assign can_ok     = segment_line_count_code != SEG_EIGHT;          // [R9]
    assign par_active = can_parallel_in & first_can_enable_in;         // [R11]
    // both transmitters share line six in parallel mode (dominant low)
    assign tx6_drive  = can_ok & (first_can_enable_in | par_active);   // [R10]
    assign tx6_level  = first_controller_transmit_in &
                        (~par_active | second_controller_transmit_in); // [R12]
    assign tx7_drive  = can_ok & second_can_enable_in & ~par_active;   // [R10]

    assign alt_drive = seg_mask | {tx7_drive, tx6_drive, 6'b000000};   // [R13]
    assign alt_val   = (seg_mask & seg_addr_in) |
                       (~seg_mask & {second_controller_transmit_in, tx6_level, 6'b000000});
    // address lines are always push-pull; CAN lines honour the drain bits
    assign alt_od    = ~seg_mask & port_four_drain_control;            // [R3]
    // lower lines are cut at the pin only; their latch and direction keep their values
    assign connect   = {4'hF, {4{~shared_pin_enable}}};                // [R5]

    ////////////////////////////////////////////////////////////////////////////
    // line drivers

    // one cell per line
    for (genvar i = 0; i < 8; i++) begin : g_line
        epsc_pin_cell u_cell (
            .clk_in       (clk_in),
            .rst_in       (rst_in),
            .connect_in   (connect[i]),
            .alt_drive_in (alt_drive[i]),
            .alt_val_in   (alt_val[i]),
            .alt_od_in    (alt_od[i]),
            .latch_in     (port_four_data_latch[i]),
            .dir_in       (port_four_direction[i]),  // [R2]
            .drain_in     (port_four_drain_control[i]), // [R3]
            .pin_out      (line_pin_out[i]),
            .pin_oe_n_out (line_pin_oe_n_out[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // CAN receive lines

    // masked receivers idle recessive high
    assign next_rx_first  = can_ok ? pin_filt[5] : 1'b1;               // [R10]
    assign next_rx_second = ~can_ok ? 1'b1 :
                            par_active ? pin_filt[5] : pin_filt[4];    // [R11]

    // receive outputs registered, recessive from reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            first_controller_receive_out  <= 1'b1;
            second_controller_receive_out <= 1'b1;
        end else begin
            first_controller_receive_out  <= next_rx_first;
            second_controller_receive_out <= next_rx_second;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_wait_one_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
        (bus_req && avs_waitrequest_out) |=> !avs_waitrequest_out)
        else $error("waitrequest held longer than one cycle");

    chk_latch_upper_zero: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
        (avs_read_in && avs_waitrequest_out && hit_latch) |=>
        (avs_readdata_out[31:8] == 24'h000000))
        else $error("latch read shows upper bits");

    chk_drain_bits_zero: assert property (@(posedge clk_in) disable iff (rst_in) // [R4]
        (avs_read_in && avs_waitrequest_out && hit_drain) |=>
        ((avs_readdata_out & 32'hFFFFFF0F) == 32'h00000000))
        else $error("unimplemented drain bit reads one");

    chk_input_released: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
        (port_four_direction == 8'h00 && alt_drive == 8'h00) |=>
        (line_pin_oe_n_out == 8'hFF))
        else $error("input line driven");

    chk_open_drain_high: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
        (port_four_direction[4] && port_four_drain_control[4] &&
         port_four_data_latch[4] && !alt_drive[4]) |=> line_pin_oe_n_out[4])
        else $error("open-drain line drives high");

    chk_shared_off: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
        shared_pin_enable |=> (line_pin_oe_n_out[3:0] == 4'hF))
        else $error("lower lines reach pins while shared");

    chk_seg_four: assert property (@(posedge clk_in) disable iff (rst_in) // [R13]
        (segment_line_count_code == SEG_FOUR && !shared_pin_enable) |=>
        (line_pin_oe_n_out[3:0] == 4'h0 && line_pin_out[3:0] == $past(seg_addr_in[3:0])))
        else $error("segment lines not driven with address");

    chk_seg_two_gpio: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
        (segment_line_count_code == SEG_TWO && port_four_direction[3:2] == 2'b00) |=>
        (line_pin_oe_n_out[3:2] == 2'b11))
        else $error("code 11 drives line two or three");

    chk_code_frozen: assert property (@(posedge clk_in) disable iff (rst_in) // [R7]
        !$past(rst_in) |-> $stable(segment_line_count_code))
        else $error("selection code changed after reset");

    chk_can_masked: assert property (@(posedge clk_in) disable iff (rst_in) // [R9]
        (segment_line_count_code == SEG_EIGHT && !shared_pin_enable) |=>
        (first_controller_receive_out && second_controller_receive_out &&
         line_pin_out == $past(seg_addr_in)))
        else $error("CAN not masked under eight-line code");

    chk_par_receive: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
        (par_active && can_ok) |=> (second_controller_receive_out == $past(pin_filt[5])))
        else $error("second receive not from pin five");

    chk_tx_map: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
        (tx7_drive && !port_four_drain_control[7]) |=>
        (line_pin_out[7] == $past(second_controller_transmit_in) && !line_pin_oe_n_out[7]))
        else $error("second transmit not on pin seven");

    chk_par_transmit: assert property (@(posedge clk_in) disable iff (rst_in) // [R12]
        (par_active && can_ok && !second_controller_transmit_in) |=>
        (!line_pin_out[6] && !line_pin_oe_n_out[6]))
        else $error("second transmit not remapped to pin six");

    // plain output lines show their latch when nothing else owns them
    chk_gpio_drive: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
        (port_four_direction[0] && !alt_drive[0] && !shared_pin_enable) |=>
        (!line_pin_oe_n_out[0] && line_pin_out[0] == $past(port_four_data_latch[0])))
        else $error("output line not driving its latch");

    // address lines: driver on and push-pull whatever the latch, direction and drain registers hold
    chk_seg_two_lines: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
        (segment_line_count_code == SEG_TWO && !shared_pin_enable) |=>
        (line_pin_oe_n_out[1:0] == 2'b00 && line_pin_out[1:0] == $past(seg_addr_in[1:0])))
        else $error("code 11 address lines not driven");

    chk_seg_none_gpio: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
        (segment_line_count_code == SEG_NONE && port_four_direction[3:0] == 4'h0) |=>
        (line_pin_oe_n_out[3:0] == 4'hF))
        else $error("code 01 drives a lower line");

    chk_seg_upper_push: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
        (segment_line_count_code == SEG_EIGHT) |=> (line_pin_oe_n_out[7:4] == 4'h0))
        else $error("address line released as open drain");

    // receive inputs follow the fixed map until parallel mode moves one
    chk_rx_first_map: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
        can_ok |=> (first_controller_receive_out == $past(pin_filt[5])))
        else $error("first receive not from pin five");

    chk_rx_second_map: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
        (can_ok && !par_active) |=> (second_controller_receive_out == $past(pin_filt[4])))
        else $error("second receive moved without parallel mode");

    // end of checks

endmodule : epsc_port

// ### logic/epsc_consts.svh
`ifndef EPSC_CONSTS_SVH
`define EPSC_CONSTS_SVH

// register indices; the byte address is four times the index
`define EPSC_IDX_LATCH      16'hFFC8
`define EPSC_IDX_DIR        16'hFFCA
`define EPSC_IDX_DRAIN      16'hF1CA
`define EPSC_IDX_MISC       16'hF1E0
`define EPSC_IDX_RSTCFG     16'hF1E2
`define EPSC_IDX_PINS       16'hF1E4

// reset values
`define EPSC_RST_LATCH      8'h00
`define EPSC_RST_DIR        8'h00
`define EPSC_RST_DRAIN      8'h00
`define EPSC_RST_SPE        1'b0

// field positions and masks
`define EPSC_DRAIN_MASK     8'hF0
`define EPSC_MISC_SPE_BIT   0
`define EPSC_RSTCFG_LSB     0

// lines carrying segment address per selection code
`define EPSC_SEGMASK_NONE   8'h00
`define EPSC_SEGMASK_TWO    8'h03
`define EPSC_SEGMASK_FOUR   8'h0F
`define EPSC_SEGMASK_EIGHT  8'hFF

`endif

// ### logic/epsc_pkg.sv
package epsc_pkg;

    // segment line count selection, sampled from port zero at reset
    typedef enum logic [1:0] {
        SEG_FOUR  = 2'b00,
        SEG_NONE  = 2'b01,
        SEG_EIGHT = 2'b10,
        SEG_TWO   = 2'b11
    } epsc_seg_code_type;

    // register bus phase
    typedef enum logic {
        BUS_IDLE   = 1'b0,
        BUS_ANSWER = 1'b1
    } epsc_bus_state_type;

endpackage : epsc_pkg

// ### logic/epsc_sync.sv
`timescale 1ns/1ps

module epsc_sync #(
    parameter int WIDTH = 1
) (
    // clock
    input  wire logic             clk_in,
    // asynchronous level and its filtered copy
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] filt_out
);

    logic [WIDTH-1:0] stage_a;   // first stage, read only by stage_b
    logic [WIDTH-1:0] stage_b;   // second stage
    logic [WIDTH-1:0] stage_c;   // third stage
    logic [WIDTH-1:0] next_filt; // filtered value to take

    // a bit moves only once the second and third stages agree
    assign next_filt = (~(stage_b ^ stage_c) & stage_c) | ((stage_b ^ stage_c) & filt_out);

    // no reset: the chain must pass pin levels while reset is held
    always_ff @(posedge clk_in) begin
        stage_a  <= async_in;
        stage_b  <= stage_a;
        stage_c  <= stage_b;
        filt_out <= next_filt;
    end

endmodule : epsc_sync

// ### logic/epsc_pin_cell.sv
`timescale 1ns/1ps

module epsc_pin_cell (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // line control
    input  wire logic connect_in,
    input  wire logic alt_drive_in,
    input  wire logic alt_val_in,
    input  wire logic alt_od_in,
    input  wire logic latch_in,
    input  wire logic dir_in,
    input  wire logic drain_in,
    // pin driver, enable low while driving
    output logic      pin_out,
    output logic      pin_oe_n_out
);

    logic drive;       // line wants its driver on
    logic level;       // level to put on the line
    logic open_drain;  // open-drain mode for this line
    logic next_out;    // registered pin value
    logic next_oe_n;   // registered enable

    // alternate function overrides latch and direction
    assign drive      = connect_in & (alt_drive_in | dir_in);
    assign level      = alt_drive_in ? alt_val_in : latch_in;
    assign open_drain = alt_drive_in ? alt_od_in : drain_in;
    // open drain releases a high instead of driving it
    assign next_oe_n  = ~drive | (open_drain & level);
    assign next_out   = drive & level & ~open_drain;

    // driver off and low from reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_out      <= 1'b0;
            pin_oe_n_out <= 1'b1;
        end else begin
            pin_out      <= next_out;
            pin_oe_n_out <= next_oe_n;
        end
    end

endmodule : epsc_pin_cell

// ### testbench/epsc_pins_model.sv
`timescale 1ns/1ps

module epsc_pins_model (
    // design drivers, enable low while driving
    input  wire logic [7:0] pin_in,
    input  wire logic [7:0] pin_oe_n_in,
    // outside drivers worked by the bench
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    // resolved wire levels
    output logic      [7:0] level_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // wire resolution; released lines with no outside driver float up through the board pull-up,
    // which is what turns an open-drain high into a readable 1
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n_in[i]) begin
                level_out[i] = pin_in[i];
            end else if (ext_en_in[i]) begin
                level_out[i] = ext_val_in[i];
            end else begin
                level_out[i] = 1'b1;
            end
        end
    end
endmodule : epsc_pins_model

// ### testbench/eight_bit_port_segment_can_mux_bench.sv
`timescale 1ns/1ps
`include "epsc_consts.svh"

module eight_bit_port_segment_can_mux_bench
    import epsc_pkg::*;
;
    // clock, reset and bus
    logic              clk_in, rst_in, rd_in, wr_in, wait_out;
    logic       [17:0] addr_in;
    logic       [31:0] wdata_in, rdata_out, rd;
    logic       [3:0]  be_in;
    // sideband from bus controller and can modules
    logic       [7:0]  seg_addr_in;
    logic       [1:0]  code_pins;
    logic              f_en, s_en, par, f_tx, s_tx, f_rx, s_rx;
    // pins and outside drivers
    logic       [7:0]  lvl, p_out, p_oe_n, ext_en, ext_val;
    // bench state
    int                failures, n_checks;
    logic       [7:0]  rnd, m_latch, m_dir, m_drain;
    logic              m_spe;
    epsc_seg_code_type code;
    epsc_seg_code_type cseq [4] = '{SEG_FOUR, SEG_TWO, SEG_EIGHT, SEG_NONE};

    epsc_port epsc_port_inst (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr_in),
        .avs_read_in(rd_in), .avs_write_in(wr_in), .avs_writedata_in(wdata_in),
        .avs_byteenable_in(be_in), .avs_readdata_out(rdata_out),
        .avs_waitrequest_out(wait_out), .seg_addr_in(seg_addr_in),
        .bus_port_zero_code_in(code_pins), .first_can_enable_in(f_en),
        .second_can_enable_in(s_en), .can_parallel_in(par),
        .first_controller_transmit_in(f_tx), .second_controller_transmit_in(s_tx),
        .first_controller_receive_out(f_rx), .second_controller_receive_out(s_rx),
        .line_pin_in(lvl), .line_pin_out(p_out), .line_pin_oe_n_out(p_oe_n));

    epsc_pins_model epsc_pins_model_inst (.pin_in(p_out), .pin_oe_n_in(p_oe_n),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));

    ////////////////////////////////////////////////////////////////////////////////
    // clock
    always #5 clk_in = ~clk_in;

    // random source, fixed start
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // lines given to segment address per code
    function automatic logic [7:0] seg_mask(input epsc_seg_code_type c);
        case (c)
            SEG_FOUR:  return `EPSC_SEGMASK_FOUR;
            SEG_TWO:   return `EPSC_SEGMASK_TWO;
            SEG_EIGHT: return `EPSC_SEGMASK_EIGHT;
            default:   return `EPSC_SEGMASK_NONE;
        endcase
    endfunction : seg_mask

    // expected {level, oe_n} at the pins from the bench's own register copy
    function automatic logic [15:0] exp_pins();
        logic [7:0] seg, alt, val, out, oen;
        logic       pm, lv, od, drv;
        seg = seg_mask(code);
        pm  = par & f_en;
        alt = seg;
        val = seg_addr_in;
        if (code != SEG_EIGHT) begin
            alt[6] = f_en | pm;
            val[6] = f_tx & (pm ? s_tx : 1'b1);
            alt[7] = s_en & ~pm;
            val[7] = s_tx;
        end
        for (int i = 0; i < 8; i++) begin
            lv     = alt[i] ? val[i] : m_latch[i];
            od     = ~seg[i] & m_drain[i];
            drv    = (i > 3 || !m_spe) && (alt[i] || m_dir[i]);
            oen[i] = ~drv | (od & lv);
            out[i] = drv & lv & ~od;
        end
        return {out, oen};
    endfunction : exp_pins

    ////////////////////////////////////////////////////////////////////////////////
    // comparison and closing
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // one bus cycle, entered just after a rising edge; held until waitrequest low
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        addr_in  <= {idx, 2'b00};
        wdata_in <= {24'h000000, wd};
        wr_in    <= wr;
        rd_in    <= ~wr;
        // only the watchdog ends a wait that never finishes
        do begin
            @(posedge clk_in);
        end while (wait_out !== 1'b0);
        rd = rdata_out;
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        @(posedge clk_in);
    endtask : bus

    // reset with a selection code standing on the code pins
    task automatic do_reset(input epsc_seg_code_type c);
        code_pins <= c;
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
    endtask : do_reset

    // pins, receive lines and pin-state readback against the expectation
    task automatic check_pins();
        logic [15:0] e;
        logic [7:0]  lv;
        repeat (6) @(posedge clk_in);
        e  = exp_pins();
        lv = (~e[7:0] & e[15:8]) | (e[7:0] & ((ext_en & ext_val) | ~ext_en));
        check("pin enables", {24'h0, p_oe_n}, {24'h0, e[7:0]});
        check("pin levels", {24'h0, p_out}, {24'h0, e[15:8]});
        check("first rx", {31'h0, f_rx}, {31'h0, code == SEG_EIGHT || lv[5]});
        check("second rx", {31'h0, s_rx},
            {31'h0, code == SEG_EIGHT || ((par & f_en) ? lv[5] : lv[4])});
        bus(1'b0, `EPSC_IDX_PINS, 8'h00);
        check("pin state", rd, {24'h0, lv});
    endtask : check_pins

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, far above the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        wrap_up();
    end

    // main sequence
    initial begin
        clk_in = 1'b0; rst_in = 1'b1; rd_in = 1'b0; wr_in = 1'b0; addr_in = 18'h00000;
        wdata_in = 32'h0; be_in = 4'hF; seg_addr_in = 8'h00; code_pins = 2'b01;
        {f_en, s_en, par, f_tx, s_tx} = 5'h00; ext_en = 8'h00; ext_val = 8'h00;
        failures = 0; n_checks = 0; rnd = 8'h4F;
        for (int c = 0; c < 4; c++) begin
            code = cseq[c];
            do_reset(code);
            m_latch = 8'h00; m_dir = 8'h00; m_drain = 8'h00; m_spe = 1'b0;
            bus(1'b0, `EPSC_IDX_RSTCFG, 8'h00);
            check("reset cfg", rd, {30'h0, code});
            bus(1'b0, `EPSC_IDX_LATCH, 8'h00);
            check("latch reset", rd, 32'h0);
            bus(1'b0, `EPSC_IDX_DRAIN, 8'h00);
            check("drain reset", rd, 32'h0);
            check_pins(); // untouched registers still give the segment lines
            for (int k = 0; k < 4; k++) begin
                rnd = lfsr(rnd); seg_addr_in <= rnd;
                rnd = lfsr(rnd); ext_val <= rnd; ext_en <= {rnd[2:0], rnd[7:3]};
                rnd = lfsr(rnd);
                // parallel mode forced with and without the first module
                if (k == 1 || k == 2) rnd[4:2] = {k == 1, rnd[3], 1'b1};
                {f_en, s_en, par, f_tx, s_tx} <= rnd[4:0];
                rnd = lfsr(rnd); m_latch = rnd; bus(1'b1, `EPSC_IDX_LATCH, rnd);
                rnd = lfsr(rnd); m_dir = rnd; bus(1'b1, `EPSC_IDX_DIR, rnd);
                rnd = lfsr(rnd); m_drain = rnd & `EPSC_DRAIN_MASK; bus(1'b1, `EPSC_IDX_DRAIN, rnd);
                bus(1'b0, `EPSC_IDX_LATCH, 8'h00);
                check("latch", rd, {24'h0, m_latch});
                bus(1'b0, `EPSC_IDX_DIR, 8'h00);
                check("direction", rd, {24'h0, m_dir});
                bus(1'b0, `EPSC_IDX_DRAIN, 8'h00);
                check("drain", rd, {24'h0, m_drain});
                m_spe = (k == 3);
                bus(1'b1, `EPSC_IDX_MISC, {7'h00, m_spe});
                check_pins();
            end
        end
        bus(1'b0, 16'h1234, 8'h00);
        check("unmapped read", rd, 32'h0);
        wrap_up();
    end
endmodule : eight_bit_port_segment_can_mux_bench
